//--- fcd_pkg.sv
// Package of constants and types for the memory clock divider block
//
// Function
// [R1] Read-only loaded flag in bit 7; reset clears it, first write sets it.
// [R2] Bits 6..0 readable always; only the first write after reset is accepted.
// [R3] Erase and program are blocked while the loaded flag is zero.
// [R4] Prescaler input is bus clock, or bus clock divided by 8 when bit 6 set.
// [R5] Memory clock equals selected input divided by divisor field plus one.
// [R6] Each timing pulse lasts one memory clock cycle; sequencer counts pulses. The code's pulse is one bus clock cycle wide, once per period.
// [R7] Software picks settings giving a 150 to 200 kHz memory clock.
// [R8] Software writes the divider register before any erase or program.
// [R9] Bit 7 write data ignored; any write counts as the first write. The code counts only a write to the register with wb_sel_i set.
package fcd_pkg;

  // Register map, byte addresses on the bus
  localparam logic [15:0] FCD_DIV_OFFSET   = 16'h1820;
  localparam int          FCD_ADDR_W       = 16;

  // Field positions of the divider register
  localparam int          FCD_LOADED_BIT   = 7;
  localparam int          FCD_PRESCALE_BIT = 6;
  localparam int          FCD_DIV_MSB      = 5;
  localparam int          FCD_DIV_W        = 6;

  // Reset values
  localparam logic [7:0]  FCD_DIV_RESET    = 8'h00;

  // Prescaler ratio and its counter width
  localparam int          FCD_PRESCALE     = 8;
  localparam int          FCD_PRE_W        = 3;
  localparam logic [2:0]  FCD_PRE_LAST     = 3'h7;

  // Timing figures of the allowed memory clock and of the bus clock, in kHz
  localparam int          FCD_FCLK_MIN_KHZ = 150;
  localparam int          FCD_FCLK_MAX_KHZ = 200;
  localparam int          FCD_BUS_KHZ      = 20000;

  // Settings held by the divider register
  typedef struct packed {
    logic                 loaded;
    logic                 prescale_by_eight;
    logic [FCD_DIV_W-1:0] divisor;
  } fcd_div_t;

  // Memory clock outputs toward the program and erase sequencer
  typedef struct packed {
    logic                 pulse;
    logic                 enable;
  } fcd_clk_t;

endpackage

//--- fcd_counter.sv
// Terminal count divider used for the prescaler and the main divider
`timescale 1ns/100ps
`default_nettype none
module fcd_counter #(
  parameter int W = 6
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] last_i,
  output logic              wrap_o
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // Count ticks from zero up to last_i, then wrap
  always_comb begin
    next_count = count;
    if (tick_i) begin
      if (count >= last_i) begin
        next_count = '0;
      end else begin
        next_count = count + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // Wrap is combinational so the next stage sees it in the same cycle
  assign wrap_o = tick_i && (count >= last_i);
endmodule
`default_nettype wire

//--- fcd_top.sv
// Memory clock divider register with Wishbone slave and pulse generator
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module fcd_top (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [fcd_pkg::FCD_ADDR_W-1:0] wb_adr_i,
  input  wire logic [7:0]                  wb_dat_i,
  input  wire logic                        wb_sel_i,
  output logic      [7:0]                  wb_dat_o,
  output logic                             wb_ack_o,
  output logic                             wb_err_o,
  output fcd_pkg::fcd_clk_t                mem_clk_o,
  output logic                             erase_program_allowed_o
);
  import fcd_pkg::*;

  fcd_div_t   memory_clock_divider_reg;
  fcd_div_t   next_memory_clock_divider_reg;
  logic       ack;
  logic       next_ack;
  logic       err;
  logic       next_err;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic       pulse;
  logic       next_pulse;
  logic       req;
  logic       hit;
  logic       pre_wrap;
  logic       div_tick;
  logic       div_wrap;

  // A new request only when no answer is pending, so one ack per access
  assign req = wb_cyc_i && wb_stb_i && !ack && !err;
  assign hit = (wb_adr_i == FCD_DIV_OFFSET);

  // Register update; loaded flag gates further writes
  always_comb begin
    next_memory_clock_divider_reg = memory_clock_divider_reg;
    // [R2] Accept first write only
    if (req && hit && wb_we_i && wb_sel_i &&
        !memory_clock_divider_reg.loaded) begin
      next_memory_clock_divider_reg.prescale_by_eight =
        wb_dat_i[FCD_PRESCALE_BIT];
      next_memory_clock_divider_reg.divisor = wb_dat_i[FCD_DIV_MSB:0];
      // [R1] First write sets flag
      // [R9] Bit 7 data ignored
      next_memory_clock_divider_reg.loaded = 1'b1;
    end
  end

  // Bus answer: ack on mapped address, err elsewhere, one cycle later
  always_comb begin
    next_ack   = 1'b0;
    next_err   = 1'b0;
    next_rdata = rdata;
    if (req) begin
      next_ack   = hit;
      next_err   = !hit;
      // Unmapped reads return zero
      next_rdata = hit ? memory_clock_divider_reg : 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      memory_clock_divider_reg <= FCD_DIV_RESET;
      ack                      <= 1'b0;
      err                      <= 1'b0;
      rdata                    <= 8'h00;
    end else begin
      memory_clock_divider_reg <= next_memory_clock_divider_reg;
      ack                      <= next_ack;
      err                      <= next_err;
      rdata                    <= next_rdata;
    end
  end

  assign wb_ack_o = ack;
  assign wb_err_o = err;
  assign wb_dat_o = rdata;

  // [R4] Divide by eight prescaler
  fcd_counter #(
    .W (FCD_PRE_W)
  ) u_prescale (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (1'b1),
    .last_i (FCD_PRE_LAST),
    .wrap_o (pre_wrap)
  );

  // [R4] Select prescaled or bus clock
  assign div_tick = memory_clock_divider_reg.prescale_by_eight ?
                    pre_wrap : 1'b1;

  // [R5] Divide by divisor plus one
  fcd_counter #(
    .W (FCD_DIV_W)
  ) u_divider (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (div_tick),
    .last_i (memory_clock_divider_reg.divisor),
    .wrap_o (div_wrap)
  );

  // [R6] One pulse per memory clock period, held off until loaded
  always_comb begin
    next_pulse = div_wrap && memory_clock_divider_reg.loaded;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse <= 1'b0;
    end else begin
      pulse <= next_pulse;
    end
  end

  // [R3] Gate erase and program
  assign erase_program_allowed_o = memory_clock_divider_reg.loaded;
  // One driver for the whole struct; pulse is the upper member
  assign mem_clk_o = {pulse, memory_clock_divider_reg.loaded};
endmodule
`default_nettype wire

//--- fcd_properties.sv
// Port assertions of the memory clock divider
`timescale 1ns/100ps
`default_nettype none
module fcd_chk (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic              wb_sel_i,
  input wire logic [15:0]       wb_adr_i,
  input wire logic [7:0]        wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              wb_err_o,
  input wire fcd_pkg::fcd_clk_t mem_clk_o,
  input wire logic              erase_program_allowed_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A request is taken only when no answer is pending
  logic take;
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  chk_gate_flag: assert property (
    erase_program_allowed_o == mem_clk_o.enable) else $error("gate");
  chk_no_pulse: assert property (
    !mem_clk_o.enable |-> !mem_clk_o.pulse) else $error("early pulse");
  chk_flag_hold: assert property (
    mem_clk_o.enable |=> mem_clk_o.enable) else $error("flag lost");
  chk_flag_set: assert property (
    take && wb_we_i && wb_sel_i && wb_adr_i == 16'h1820
    |=> mem_clk_o.enable) else $error("flag not set");
  chk_flag_rise: assert property (
    $rose(mem_clk_o.enable) |-> $past(take && wb_we_i && wb_sel_i &&
    wb_adr_i == fcd_pkg::FCD_DIV_OFFSET)) else $error("flag rose alone");
  chk_ack_next: assert property (
    take |=> wb_ack_o || wb_err_o) else $error("no answer");
  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_read_flag: assert property (
    wb_ack_o && !$past(wb_we_i) |-> wb_dat_o[7] == mem_clk_o.enable)
    else $error("flag bit");
endmodule
bind fcd_top fcd_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .mem_clk_o(mem_clk_o),
  .erase_program_allowed_o(erase_program_allowed_o));
`default_nettype wire

//--- fcd_top_tb.sv
// Self-checking bench of the memory clock divider
`timescale 1ns/100ps
`default_nettype none
module fcd_top_tb;
  import fcd_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, e, ack, err, ok;
  logic        sel = 1;
  logic [15:0] adr = 0;
  logic [7:0]  dat = 0, rd, dat_o, d;
  fcd_clk_t    mc;
  logic [16:0] rnd = 17'h126F5;
  int          errors = 0, samples_checked = 0, m, t0, n;
  // Bus clock at 20 MHz
  always #25 clk_i = ~clk_i;
  fcd_top u_fcd_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
    .mem_clk_o(mc), .erase_program_allowed_o(ok));
  function automatic logic [16:0] lfsr(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction
  task automatic check(input logic [7:0] s, input logic [7:0] x);
    samples_checked++;
    if (s !== x) begin
      errors++;
      $display("wrong value at %0t: %h expected %h", $time, s, x);
    end
  endtask
  // One classic cycle; the wait is bounded so a dead slave cannot hang
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [7:0] v);
    cyc <= 1;
    we <= w;
    adr <= a;
    dat <= v;
    n = 0;
    do @(posedge clk_i); while (!(ack | err) && ++n < 20);
    if (n >= 20) errors++;
    rd = dat_o;
    e = err;
    cyc <= 0;
    @(posedge clk_i);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One pass for each prescaler setting
  initial begin
    for (int p = 0; p < 2; p++) begin
      rst_i <= 1;
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      bus(0, 16'h1820, 8'h00);
      check(rd, 8'h00); // clear after reset
      check(8'(ok), 8'h00); // blocked before loading
      // A write without its byte select must not count as the first
      sel <= 0;
      bus(1, 16'h1820, 8'h55);
      sel <= 1;
      bus(0, 16'h1820, 8'h00);
      check(rd, 8'h00); // deselected write ignored
      rnd = lfsr(rnd);
      // Divisor 12..15 keeps the prescaled clock in 150 to 200 kHz
      d = {rnd[2], p[0], 6'(12 + rnd[1:0])};
      m = 128 + p * 64 + 12 + rnd[1:0];
      // Divider written before erase or program is relied on
      for (int w = 0; w < 2; w++) begin
        bus(1, 16'h1820, w ? ~d : d);
        bus(0, 16'h1820, 8'h00);
        check(rd, 8'(m)); // only first write lands
      end
      check(8'(ok), 8'h01); // allowed once loaded
      bus(0, 16'h1821, 8'h00);
      check(8'(e), 8'h01);
      // Find one pulse, then count edges to the next; both waits bounded
      n = 0;
      while (!mc.pulse && n < 300) begin
        @(posedge clk_i);
        n++;
      end
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (!mc.pulse && n < 300);
      if (n >= 300) errors++;
      check(8'(n), 8'((p ? FCD_PRESCALE : 1) * (m % 64 + 1)));
      $display("pass %0d done", p);
    end
    print_verdict;
  end
  // Watchdog far beyond the expected run
  initial begin
    #1000000;
    errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
